// *** hdl/hss_i2c_engine.sv ***
// Serial bus slave engine: start/stop detection, address match, byte shifting.
// Assumes scl is the bus clock itself and sda_in is the bus data level.
`timescale 1ns/1ps
module hss_i2c_engine
   import hss_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT
) (
   input logic scl,
   input logic sda_in,
   input logic rst,
   output logic sda_oe_n,
   hss_link_if.engine link
);
   logic bit_q;
   logic start_tog_q = 1'b0;
   logic stop_tog_q = 1'b0;
   logic start_seen_q;
   logic stop_seen_q;
   hss_eng_t st_q;
   logic [2:0] cnt_q;
   logic [7:0] sh_q;
   logic [7:0] tx_q;
   logic drive_q;
   logic start_pend;
   logic stop_pend;

   // ==========================================================================
   // Line sampling and start/stop capture
   // Data is taken while the clock is high
   always_ff @(posedge scl) begin
      bit_q <= sda_in;
   end
   // Data edges while clock is high mark start and stop; toggles need no reset
   always_ff @(negedge sda_in) begin
      if (scl) begin
         start_tog_q <= ~start_tog_q;
      end
   end
   always_ff @(posedge sda_in) begin
      if (scl) begin
         stop_tog_q <= ~stop_tog_q;
      end
   end
   // Seen copies close each event at the next falling clock edge
   always_ff @(negedge scl) begin
      start_seen_q <= start_tog_q;
      stop_seen_q <= stop_tog_q;
   end
   assign start_pend = start_tog_q != start_seen_q;
   assign stop_pend = stop_tog_q != stop_seen_q;

   // ==========================================================================
   // Byte engine; the line changes only on falling clock edges
   always_ff @(negedge scl) begin
      link.start_p <= 1'b0;
      link.wr_p <= 1'b0;
      link.rd_p <= 1'b0;
      if (rst) begin
         st_q <= E_IDLE;
         cnt_q <= 3'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         drive_q <= 1'b0;
         link.wr_data <= 8'h00;
      end else if (start_pend) begin
         // Start or repeated start abandons whatever was running
         st_q <= E_ADDR;
         cnt_q <= 3'h0;
         drive_q <= 1'b0;
         link.start_p <= 1'b1;
      end else if (stop_pend) begin
         st_q <= E_IDLE;
         drive_q <= 1'b0;
      end else begin
         case (st_q)
            E_ADDR: begin
               sh_q <= {sh_q[6:0], bit_q};
               cnt_q <= cnt_q + 3'h1;
               if (cnt_q == 3'h7) begin
                  if (sh_q[6:0] == DEV_ADDR) begin
                     drive_q <= 1'b1;
                     tx_q[0] <= bit_q;
                     st_q <= E_AACK;
                  end else begin
                     st_q <= E_IDLE;
                  end
               end
            end
            E_AACK: begin
               cnt_q <= 3'h0;
               if (tx_q[0]) begin
                  drive_q <= ~link.rd_data[7];
                  tx_q <= {link.rd_data[6:0], 1'b0};
                  link.rd_p <= 1'b1;
                  st_q <= E_RD;
               end else begin
                  drive_q <= 1'b0;
                  st_q <= E_WR;
               end
            end
            E_WR: begin
               sh_q <= {sh_q[6:0], bit_q};
               cnt_q <= cnt_q + 3'h1;
               if (cnt_q == 3'h7) begin
                  link.wr_data <= {sh_q[6:0], bit_q};
                  link.wr_p <= 1'b1;
                  drive_q <= 1'b1;
                  st_q <= E_WACK;
               end
            end
            E_WACK: begin
               drive_q <= 1'b0;
               cnt_q <= 3'h0;
               st_q <= E_WR;
            end
            E_RD: begin
               cnt_q <= cnt_q + 3'h1;
               if (cnt_q == 3'h7) begin
                  drive_q <= 1'b0;
                  st_q <= E_RACK;
               end else begin
                  drive_q <= ~tx_q[7];
                  tx_q <= {tx_q[6:0], 1'b0};
               end
            end
            E_RACK: begin
               // Master ack asks for the next byte; a nack ends the read
               cnt_q <= 3'h0;
               if (!bit_q) begin
                  drive_q <= ~link.rd_data[7];
                  tx_q <= {link.rd_data[6:0], 1'b0};
                  link.rd_p <= 1'b1;
                  st_q <= E_RD;
               end else begin
                  st_q <= E_IDLE;
               end
            end
            default: begin
               drive_q <= 1'b0;
               st_q <= E_IDLE;
            end
         endcase
      end
   end

   assign link.busy = st_q != E_IDLE;
   assign sda_oe_n = ~drive_q;

   // ==========================================================================
   // Checks
   property p_start_restart;
      @(negedge scl) disable iff (rst) start_pend |=> st_q == E_ADDR && !drive_q;
   endproperty
   a_start_restart: assert property (p_start_restart) else $error("start not restarting");
   property p_addr_ack;
      @(negedge scl) disable iff (rst)
         (st_q == E_ADDR && cnt_q == 3'h7 && sh_q[6:0] == DEV_ADDR && !start_pend
         && !stop_pend) |=> drive_q ##1 !drive_q || st_q == E_RD;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
endmodule : hss_i2c_engine

// *** hdl/hss_link_if.sv ***
// Byte-level link between the serial bus engine and the register logic.
// Everything here lives on the falling edge of the bus clock.
`timescale 1ns/1ps
interface hss_link_if;
   logic start_p;
   logic wr_p;
   logic [7:0] wr_data;
   logic rd_p;
   logic [7:0] rd_data;
   logic busy;

   modport engine (output start_p, output wr_p, output wr_data, output rd_p,
      output busy, input rd_data);
   modport regs (input start_p, input wr_p, input wr_data, input rd_p,
      input busy, output rd_data);
endinterface : hss_link_if

// *** hdl/hss_pkg.sv ***
// Shared constants and types for the hall sensor readout and sleep control block.
// Assumes a 40 MHz system clock and a bus clock that is driven by an outside master.
package hss_pkg;

   // ==========================================================================
   // Register map
   localparam logic [7:0] REG_TEMP = 8'h1d;
   localparam logic [7:0] REG_FIELD = 8'h1f;
   localparam logic [7:0] REG_SLEEP = 8'h20;
   localparam logic [7:0] REG_ACCESS = 8'h24;
   localparam logic [31:0] ACCESS_CODE = 32'h2c413534;
   localparam int SENS_W = 12;
   localparam int SLEEP_POS = 0;
   localparam logic SLEEP_RST = 1'b0;
   localparam logic [1:0] LAST_BYTE = 2'h3;
   // Nominal temperature slope in counts per degree, produced by the analog core
   localparam int TEMP_LSB_PER_DEG = 8;
   // Bus address of this slave; the value is arbitrary
   localparam logic [6:0] DEV_ADDR_DFLT = 7'h3a;

   // ==========================================================================
   // Wake timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int WAKE_CLK_US = 50;
   localparam int WAKE_RAW_US = 150;
   localparam int WAKE_FULL_US = 500;
   localparam int WAKE_CNT_W = 24;
   localparam logic [WAKE_CNT_W-1:0] WAKE_CLK_CYC =
      WAKE_CNT_W'(WAKE_CLK_US * 1000 / CLK_PERIOD_NS);
   localparam int WAKE_RAW_CYC_DFLT = WAKE_RAW_US * 1000 / CLK_PERIOD_NS;
   localparam int WAKE_FULL_CYC_DFLT = WAKE_FULL_US * 1000 / CLK_PERIOD_NS;

   // ==========================================================================
   // State types
   typedef enum logic [2:0] {WK_ASLEEP, WK_CLK, WK_RAW, WK_COMP, WK_ACTIVE} hss_wake_t;
   typedef enum logic [2:0] {E_IDLE, E_ADDR, E_AACK, E_WR, E_WACK, E_RD, E_RACK} hss_eng_t;

endpackage : hss_pkg

// *** hdl/hss_top.sv ***
// Hall sensor register readout and sleep control: bus registers on the bus clock,
// wake sequencing and sample holding on the system clock.
// Assumes FIELD_IN/TEMP_IN/SAMPLE_STROBE come from the analog core on CLK.
`timescale 1ns/1ps
module hss_top
   import hss_pkg::*;
#(
   parameter logic [WAKE_CNT_W-1:0] WAKE_RAW_CYC = WAKE_CNT_W'(WAKE_RAW_CYC_DFLT),
   parameter logic [WAKE_CNT_W-1:0] WAKE_FULL_CYC = WAKE_CNT_W'(WAKE_FULL_CYC_DFLT),
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT
) (
   input logic CLK,
   input logic RESET,
   input logic SCL,
   input logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE_N,
   input logic [SENS_W-1:0] FIELD_IN,
   input logic [SENS_W-1:0] TEMP_IN,
   input logic SAMPLE_STROBE,
   output logic SUBSYS_PWR_EN,
   output logic SYS_CLK_RUN,
   output logic FIELD_RAW_OK,
   output logic FIELD_ACCURATE,
   output logic ACCESS_UNLOCKED
);
   // Bus clock side
   logic rst_meta_q;
   logic rst_scl_q;
   logic [7:0] ptr_q;
   logic [1:0] biw_q;
   logic expect_ptr_q;
   logic [23:0] wacc_q;
   logic sleep_q;
   logic unlocked_q;
   logic hold_q;
   logic ack_meta_q;
   logic ack_s_q;
   logic commit;
   logic [31:0] word_in;
   logic [31:0] rd_word;
   // System clock side
   logic sleep_meta_q;
   logic sleep_s_q;
   logic hold_meta_q;
   logic hold_s_q;
   logic unl_meta_q;
   logic hold_ack_q;
   hss_wake_t wake_q;
   hss_wake_t wake_d;
   logic [WAKE_CNT_W-1:0] wake_cnt_q;
   logic [SENS_W-1:0] field_sh_q;
   logic [SENS_W-1:0] temp_sh_q;

   hss_link_if link ();

   // ==========================================================================
   // Decode helpers
   // Full register word for an address; unmapped and reserved bits read zero
   function automatic logic [31:0] reg_word(input logic [7:0] a, input logic [SENS_W-1:0] f,
         input logic [SENS_W-1:0] t, input logic s);
      reg_word = 32'h0000_0000;
      case (a)
         REG_FIELD: reg_word = {20'h00000, f};
         REG_TEMP: reg_word = {20'h00000, t};
         REG_SLEEP: reg_word = {31'h0000_0000, s};
         default: reg_word = 32'h0000_0000;
      endcase
   endfunction : reg_word

   // Byte of a word, most significant byte first
   function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] i);
      word_byte = w[8'(31 - 8 * i) -: 8];
   endfunction : word_byte

   // ==========================================================================
   // Bus engine
   hss_i2c_engine #(
      .DEV_ADDR(DEV_ADDR)
   ) u_engine (
      .scl(SCL),
      .sda_in(SDA_IN),
      .rst(rst_scl_q),
      .sda_oe_n(SDA_OE_N),
      .link(link)
   );
   // Open-drain: only ever pulls low
   assign SDA_OUT = 1'b0;

   // ==========================================================================
   // Bus clock domain
   // Reset brought over to the bus clock; takes effect only while the bus clock runs
   always_ff @(negedge SCL) begin
      rst_meta_q <= RESET;
      rst_scl_q <= rst_meta_q;
   end

   // Every fourth byte completes a word for the current pointer
   assign word_in = {wacc_q, link.wr_data};
   assign commit = link.wr_p && !expect_ptr_q && biw_q == LAST_BYTE;

   // Pointer and byte position; first written byte sets the pointer
   always_ff @(negedge SCL) begin
      if (rst_scl_q) begin
         ptr_q <= 8'h00;
         biw_q <= 2'h0;
         expect_ptr_q <= 1'b1;
         wacc_q <= 24'h000000;
      end else if (link.start_p) begin
         biw_q <= 2'h0;
         expect_ptr_q <= 1'b1;
      end else if (link.wr_p && expect_ptr_q) begin
         ptr_q <= link.wr_data;
         expect_ptr_q <= 1'b0;
      end else if (link.wr_p || link.rd_p) begin
         wacc_q <= {wacc_q[15:0], link.wr_data};
         biw_q <= biw_q + 2'h1;
         if (biw_q == LAST_BYTE) begin
            ptr_q <= ptr_q + 8'h01;
         end
      end
   end

   // Sleep bit is writable whether or not access is unlocked
   always_ff @(negedge SCL) begin
      if (rst_scl_q) begin
         sleep_q <= SLEEP_RST;
      end else if (commit && ptr_q == REG_SLEEP) begin
         sleep_q <= word_in[SLEEP_POS];
      end
   end

   // Unlock sticks until reset; no writable target is gated by it, so no write is ever blocked
   always_ff @(negedge SCL) begin
      if (rst_scl_q) begin
         unlocked_q <= 1'b0;
      end else if (commit && ptr_q == REG_ACCESS && word_in == ACCESS_CODE) begin
         unlocked_q <= 1'b1;
      end
   end

   // Freeze request for the sample holders while a transfer is open
   always_ff @(negedge SCL) begin
      if (rst_scl_q) begin
         hold_q <= 1'b0;
      end else begin
         hold_q <= link.busy;
      end
   end
   always_ff @(negedge SCL) begin
      ack_meta_q <= hold_ack_q;
      ack_s_q <= ack_meta_q;
   end

   // Holders are read only once the freeze is acknowledged, so no word tears
   assign rd_word = reg_word(ptr_q, ack_s_q ? field_sh_q : '0, ack_s_q ? temp_sh_q : '0,
      sleep_q);
   assign link.rd_data = word_byte(rd_word, biw_q);

   // ==========================================================================
   // System clock domain
   // Level crossings into the system clock
   always_ff @(posedge CLK) begin
      sleep_meta_q <= sleep_q;
      sleep_s_q <= sleep_meta_q;
      hold_meta_q <= hold_q;
      hold_s_q <= hold_meta_q;
      unl_meta_q <= unlocked_q;
      ACCESS_UNLOCKED <= unl_meta_q;
   end
   always_ff @(posedge CLK) begin
      if (RESET) begin
         hold_ack_q <= 1'b0;
      end else begin
         hold_ack_q <= hold_s_q;
      end
   end

   // Wake sequence; reset starts it just as a wake does
   always_comb begin
      wake_d = wake_q;
      if (sleep_s_q) begin
         wake_d = WK_ASLEEP;
      end else begin
         case (wake_q)
            WK_ASLEEP: wake_d = WK_CLK;
            WK_CLK: if (wake_cnt_q == WAKE_CLK_CYC - 1'b1) wake_d = WK_RAW;
            WK_RAW: if (wake_cnt_q == WAKE_RAW_CYC - 1'b1) wake_d = WK_COMP;
            WK_COMP: if (wake_cnt_q == WAKE_FULL_CYC - 1'b1) wake_d = WK_ACTIVE;
            WK_ACTIVE: wake_d = WK_ACTIVE;
            default: wake_d = WK_ASLEEP;
         endcase
      end
   end
   always_ff @(posedge CLK) begin
      if (RESET) begin
         wake_q <= WK_CLK;
      end else begin
         wake_q <= wake_d;
      end
   end

   // Time since wake; stops once fully awake
   always_ff @(posedge CLK) begin
      if (RESET || wake_d == WK_ASLEEP || wake_q == WK_ASLEEP) begin
         wake_cnt_q <= '0;
      end else if (wake_q != WK_ACTIVE) begin
         wake_cnt_q <= wake_cnt_q + 1'b1;
      end
   end

   // Power and readiness flags follow the next wake state
   always_ff @(posedge CLK) begin
      if (RESET) begin
         SUBSYS_PWR_EN <= 1'b1;
         SYS_CLK_RUN <= 1'b0;
         FIELD_RAW_OK <= 1'b0;
         FIELD_ACCURATE <= 1'b0;
      end else begin
         SUBSYS_PWR_EN <= wake_d != WK_ASLEEP;
         SYS_CLK_RUN <= wake_d inside {WK_RAW, WK_COMP, WK_ACTIVE};
         FIELD_RAW_OK <= wake_d inside {WK_COMP, WK_ACTIVE};
         FIELD_ACCURATE <= wake_d == WK_ACTIVE;
      end
   end

   // Sample holders: cleared while powered down, frozen while the bus reads them.
   // Temperature slope and compensation are produced by the analog core.
   always_ff @(posedge CLK) begin
      if (RESET || !SUBSYS_PWR_EN) begin
         field_sh_q <= '0;
         temp_sh_q <= '0;
      end else if (SAMPLE_STROBE && SYS_CLK_RUN && !hold_s_q) begin
         field_sh_q <= FIELD_IN;
         temp_sh_q <= TEMP_IN;
      end
   end

   // ==========================================================================
   // Checks
   property p_sleep_pwr;
      @(posedge CLK) disable iff (RESET) sleep_s_q |=> !SUBSYS_PWR_EN;
   endproperty
   a_sleep_pwr: assert property (p_sleep_pwr) else $error("power kept while asleep");
   property p_wake_pwr;
      @(posedge CLK) disable iff (RESET)
         $fell(sleep_s_q) |=> SUBSYS_PWR_EN ##1 SUBSYS_PWR_EN;
   endproperty
   a_wake_pwr: assert property (p_wake_pwr) else $error("no restart on wake");
   property p_clk_time;
      @(posedge CLK) disable iff (RESET)
         $rose(SYS_CLK_RUN) |-> $past(wake_cnt_q) == WAKE_CLK_CYC - 1'b1;
   endproperty
   a_clk_time: assert property (p_clk_time) else $error("clock ready at wrong time");
   property p_raw_time;
      @(posedge CLK) disable iff (RESET)
         $rose(FIELD_RAW_OK) |-> $past(wake_cnt_q) == WAKE_RAW_CYC - 1'b1 && SYS_CLK_RUN;
   endproperty
   a_raw_time: assert property (p_raw_time) else $error("raw field at wrong time");
   property p_full_time;
      @(posedge CLK) disable iff (RESET)
         $rose(FIELD_ACCURATE) |-> $past(wake_cnt_q) == WAKE_FULL_CYC - 1'b1 && FIELD_RAW_OK;
   endproperty
   a_full_time: assert property (p_full_time) else $error("full accuracy at wrong time");
   property p_wake_clear;
      @(posedge CLK) disable iff (RESET)
         !SUBSYS_PWR_EN |=> field_sh_q == '0 && temp_sh_q == '0;
   endproperty
   a_wake_clear: assert property (p_wake_clear) else $error("holders kept over sleep");
   property p_sleep_reset;
      @(negedge SCL) rst_scl_q |=> !sleep_q && !unlocked_q;
   endproperty
   a_sleep_reset: assert property (p_sleep_reset) else $error("sleep bit not reset");
   property p_upper_zero;
      @(negedge SCL) disable iff (rst_scl_q)
         (ptr_q == REG_FIELD || ptr_q == REG_TEMP || ptr_q == REG_SLEEP) && biw_q == 2'h0
         |-> link.rd_data == 8'h00;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");
   property p_ptr_step;
      @(negedge SCL) disable iff (rst_scl_q)
         commit && !link.start_p |=> ptr_q == 8'($past(ptr_q) + 8'h01) && biw_q == 2'h0;
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("pointer not advanced");
   property p_unlock;
      @(negedge SCL) disable iff (rst_scl_q)
         $rose(unlocked_q) |-> $past(commit) && $past(ptr_q) == REG_ACCESS
         && $past(word_in) == ACCESS_CODE;
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock without code");
   property p_unlock_held;
      @(negedge SCL) disable iff (rst_scl_q) unlocked_q |=> unlocked_q;
   endproperty
   a_unlock_held: assert property (p_unlock_held) else $error("unlock lost");
   // Sleep bit moves only on a committed word for its own address
   property p_sleep_write;
      @(negedge SCL) disable iff (rst_scl_q)
         commit && ptr_q == REG_SLEEP |=> sleep_q == $past(word_in[SLEEP_POS]);
   endproperty
   a_sleep_write: assert property (p_sleep_write) else $error("sleep write lost");
   property p_sleep_keep;
      @(negedge SCL) disable iff (rst_scl_q)
         !(commit && ptr_q == REG_SLEEP) |=> $stable(sleep_q);
   endproperty
   a_sleep_keep: assert property (p_sleep_keep) else $error("sleep bit moved");
   // Last byte of the sleep word carries only the bit itself
   property p_sleep_byte;
      @(negedge SCL) disable iff (rst_scl_q)
         ptr_q == REG_SLEEP && biw_q == LAST_BYTE |-> link.rd_data == {7'h00, sleep_q};
   endproperty
   a_sleep_byte: assert property (p_sleep_byte) else $error("sleep byte wrong");
   // Holders stand still while the bus side owns them, so a read never tears
   property p_hold_freeze;
      @(posedge CLK) disable iff (RESET)
         hold_s_q && SUBSYS_PWR_EN |=> $stable(field_sh_q) && $stable(temp_sh_q);
   endproperty
   a_hold_freeze: assert property (p_hold_freeze) else $error("holder moved");

   c_full_wake: cover property (@(posedge CLK) disable iff (RESET) $rose(FIELD_ACCURATE));
   c_sleep: cover property (@(posedge CLK) disable iff (RESET) $fell(SUBSYS_PWR_EN));
   c_unlock: cover property (@(negedge SCL) disable iff (rst_scl_q) $rose(unlocked_q));
   c_read: cover property (@(negedge SCL) disable iff (rst_scl_q)
      link.rd_p && ptr_q == REG_FIELD);
endmodule : hss_top

// *** test/hall_sensor_register_sleep_ctrl_tb_top.sv ***
// Bench for the sensor readout and sleep control block.
// Assumes the bus master model; the data wire has a pull-up.
`timescale 1ns/1ps
module hall_sensor_register_sleep_ctrl_tb_top;
   import hss_pkg::*;
   logic CLK = 1'b0;
   logic clk_en = 1'b1;
   logic RESET = 1'b1;
   logic SAMPLE_STROBE = 1'b0;
   logic [SENS_W-1:0] FIELD_IN = '0;
   logic [SENS_W-1:0] TEMP_IN = '0;
   logic SCL, sda_drv, SDA_OUT, SDA_OE_N, SUBSYS_PWR_EN, SYS_CLK_RUN;
   logic FIELD_RAW_OK, FIELD_ACCURATE, ACCESS_UNLOCKED, nak;
   logic [63:0] d;
   int n_fail = 0;
   int num_checks = 0;
   int ticks = 0;
   // Pull-up wins unless the master or the slave pulls low
   wire sda_line = sda_drv & (SDA_OE_N !== 1'b0);
   hss_top #(.WAKE_RAW_CYC(24'd2100), .WAKE_FULL_CYC(24'd2200)) hss_top_inst (.CLK, .RESET,
      .SCL, .SDA_IN(sda_line), .SDA_OUT, .SDA_OE_N, .FIELD_IN, .TEMP_IN, .SAMPLE_STROBE,
      .SUBSYS_PWR_EN, .SYS_CLK_RUN, .FIELD_RAW_OK, .FIELD_ACCURATE, .ACCESS_UNLOCKED);
   hss_bus_master hss_bus_master_inst (.scl(SCL), .sda_drv(sda_drv), .sda_line(sda_line));
   // ======================================
   // Gated clock; the tick count keeps going so a stopped clock still times out
   always #12.5 begin
      CLK = clk_en & ~CLK;
      ticks++;
      if (ticks == 60000) begin
         n_fail++;
         tally_and_finish;
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
      #2;
   endtask : cyc
   task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   // ======================================
   // Bus side needs clock edges with data high to see the reset
   task automatic do_reset;
      cyc(1);
      fork
         cyc(16);
         hss_bus_master_inst.pulses(6);
      join
      cyc(1);
      RESET = 1'b0;
      fork
         hss_bus_master_inst.pulses(3);
      join_none
   endtask : do_reset
   // Staged wake, counted from power returning; 10 cycles slack each side of the clock stage, 90 early and 10 late for the others
   task automatic test_wake;
      int t;
      t = 0;
      while (SUBSYS_PWR_EN !== 1'b1 && t < 100) begin
         cyc(1);
         t++;
      end
      check("power on", SUBSYS_PWR_EN, 1);
      cyc(1990);
      check("clock stage early", SYS_CLK_RUN, 0);
      cyc(20);
      check("clock stage", {SYS_CLK_RUN, FIELD_RAW_OK}, 2'b10);
      cyc(100);
      check("raw stage", {FIELD_RAW_OK, FIELD_ACCURATE}, 2'b10);
      cyc(100);
      check("full stage", FIELD_ACCURATE, 1);
      $display("test wake done");
   endtask : test_wake
   // Negative field, +2 degrees; two words read from one pointer
   task automatic test_read;
      FIELD_IN = 12'h9a5;
      TEMP_IN = 12'h010;
      SAMPLE_STROBE = 1'b1;
      cyc(1);
      SAMPLE_STROBE = 1'b0;
      cyc(2);
      hss_bus_master_inst.rd(REG_FIELD, 2, d, nak);
      check("field then sleep", d, 64'h0000_09a5_0000_0000);
      check("read acks", nak, 0);
      hss_bus_master_inst.rd(REG_TEMP, 1, d, nak);
      check("temperature", d, 64'h010);
      hss_bus_master_inst.rd(8'h21, 1, d, nak);
      check("unmapped", d, 64'h0);
      // A foreign address must go unanswered, leaving the pull-up to win
      nak = 1'b0;
      hss_bus_master_inst.start_c;
      hss_bus_master_inst.tx({DEV_ADDR_DFLT ^ 7'h01, 1'b1}, nak);
      hss_bus_master_inst.stop_c;
      check("foreign address", nak, 1);
      check("data out level", SDA_OUT, 0);
      $display("test read done");
   endtask : test_read
   task automatic test_unlock;
      check("locked", ACCESS_UNLOCKED, 0);
      hss_bus_master_inst.wr(REG_ACCESS, 32'h2c413535, 4, nak);
      hss_bus_master_inst.rd(REG_SLEEP, 1, d, nak);
      cyc(10);
      check("wrong code", ACCESS_UNLOCKED, 0);
      hss_bus_master_inst.wr(REG_ACCESS, ACCESS_CODE, 4, nak);
      check("write acks", nak, 0);
      hss_bus_master_inst.rd(REG_SLEEP, 1, d, nak);
      cyc(10);
      check("unlocked", ACCESS_UNLOCKED, 1);
      $display("test unlock done");
   endtask : test_unlock
   // Sleep, partial clear dropped, clear with the system clock stopped
   task automatic test_sleep;
      hss_bus_master_inst.wr(REG_SLEEP, 32'h1, 4, nak);
      hss_bus_master_inst.rd(REG_SLEEP, 1, d, nak);
      cyc(10);
      check("sleep bit", d, 64'h1);
      check("asleep", {SUBSYS_PWR_EN, SYS_CLK_RUN, FIELD_ACCURATE}, 3'b000);
      hss_bus_master_inst.wr(REG_SLEEP, 32'h0, 3, nak);
      hss_bus_master_inst.rd(REG_SLEEP, 1, d, nak);
      check("partial word", d, 64'h1);
      clk_en = 1'b0;
      hss_bus_master_inst.wr(REG_SLEEP, 32'h0, 4, nak);
      check("clear acks", nak, 0);
      clk_en = 1'b1;
      test_wake;
      // Read only after the wake wait; the field holder must come back empty
      hss_bus_master_inst.rd(REG_FIELD, 2, d, nak);
      check("clear unclocked", d[31:0], 64'h0);
      check("field after wake", d[63:32], 64'h0);
      check("unlock kept", ACCESS_UNLOCKED, 1);
      $display("test sleep done");
   endtask : test_sleep
   // ======================================
   // Main sequence
   initial begin
      do_reset;
      test_wake;
      test_read;
      test_unlock;
      test_sleep;
      tally_and_finish;
   end
endmodule : hall_sensor_register_sleep_ctrl_tb_top

// *** test/hss_bus_master.sv ***
// Bus master model: makes the serial clock, drives data, runs register transfers.
// Assumes the bench resolves the data wire from both pull-downs and a pull-up.
`timescale 1ns/1ps
module hss_bus_master
   import hss_pkg::*;
#(
   parameter logic [6:0] ADDR = DEV_ADDR_DFLT
) (
   output logic scl,
   output logic sda_drv,
   input wire logic sda_line
);
   // ======================================
   // Idle: clock stands high, data released
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // One bit, data changed only while the clock is low
   task automatic bit_io(input logic b, output logic r);
      sda_drv = b;
      #31.25 scl = 1'b1;
      #31.25 r = sda_line;
      #31.25 scl = 1'b0;
      #31.25;
   endtask : bit_io
   // Free clock pulses, only used to carry reset and its release into the bus side
   task automatic pulses(input int n);
      repeat (n) begin
         #62.5 scl = 1'b0;
         #62.5 scl = 1'b1;
      end
   endtask : pulses
   task automatic start_c;
      sda_drv = 1'b1;
      #31.25 scl = 1'b1;
      #31.25 sda_drv = 1'b0;
      #31.25 scl = 1'b0;
      #31.25;
   endtask : start_c
   task automatic stop_c;
      sda_drv = 1'b0;
      #31.25 scl = 1'b1;
      #31.25 sda_drv = 1'b1;
      #62.5;
   endtask : stop_c
   task automatic tx(input logic [7:0] b, inout logic nak);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      nak |= r;
   endtask : tx
   // Write nb bytes of w, most significant first, from one pointer
   task automatic wr(input logic [7:0] p, input logic [31:0] w, input int nb, output logic nak);
      nak = 1'b0;
      start_c;
      tx({ADDR, 1'b0}, nak);
      tx(p, nak);
      for (int i = 0; i < nb; i++) tx(w[31-8*i -: 8], nak);
      stop_c;
   endtask : wr
   // Read nw words; last byte refused so the slave lets go of the wire
   task automatic rd(input logic [7:0] p, input int nw, output logic [63:0] d, output logic nak);
      logic r;
      nak = 1'b0;
      d = '0;
      start_c;
      tx({ADDR, 1'b0}, nak);
      tx(p, nak);
      start_c;
      tx({ADDR, 1'b1}, nak);
      for (int i = 0; i < 4 * nw; i++) begin
         for (int j = 0; j < 8; j++) begin
            bit_io(1'b1, r);
            d = {d[62:0], r};
         end
         bit_io(i == 4 * nw - 1, r);
      end
      stop_c;
   endtask : rd
endmodule : hss_bus_master
